/* tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defs.vh"
module tb;
  logic        aclk, aresetn, go, sel, external_gate_pin_zero, external_gate_pin_one;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, r;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  n;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  wire         count_input_pin_zero, count_input_pin_one, overflow_flag_zero, overflow_flag_one;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  int          n_fail, checked;
  logic [1:0]  bq[$], rq[$];
  logic [31:0] dq[$], mq[$];
  tmr_top tmr_top_i (.*);
  tmr_pins tmr_pins_i (.aclk, .go, .sel, .n, .cnt_pin({count_input_pin_one, count_input_pin_zero}), .busy);
  task automatic cmp_data(string w, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", w, e, s);
    end
  endtask
  task automatic cmp_resp(string w, logic [1:0] e, logic [1:0] s);
    cmp_data(w, {30'h0, e}, {30'h0, s});
  endtask
  // Takes the oldest note off as each answer is taken
  always @(negedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) cmp_resp("bresp", bq.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) begin
      cmp_resp("rresp", rq.pop_front(), s_axi_rresp);
      cmp_data("rdata", dq.pop_front(), s_axi_rdata & mq.pop_front());
    end
  end
  task automatic wr(logic [9:0] a, logic [31:0] d, logic [1:0] e = `RESP_OKAY);
    logic aw, w, b;
    @(posedge aclk);
    bq.push_back(e);
    s_axi_awaddr <= {22'h0, a};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(logic [9:0] a, logic [31:0] e, logic [31:0] m, logic [1:0] x = `RESP_OKAY);
    logic ar, v;
    @(posedge aclk);
    rq.push_back(x);
    dq.push_back(e & m);
    mq.push_back(m);
    s_axi_araddr <= {22'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge aclk);
      {ar, v} = {s_axi_arready, s_axi_rvalid};
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!v);
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(logic s, logic [7:0] k);
    @(posedge aclk);
    {sel, n, go} <= {s, k, 1'b1};
    @(posedge aclk);
    go <= 1'b0;
    do @(negedge aclk); while (busy);
    repeat (4) @(posedge aclk);
  endtask
  // Twelve clocks to a machine cycle, so 40 clocks give at least three ticks
  task automatic idle(int k = 40);
    repeat (k) @(posedge aclk);
  endtask
  task automatic end_sim;
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    end_sim();
  end
  // Test sequence
  initial begin
    {aresetn, go, sel, external_gate_pin_zero, external_gate_pin_one} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, n} = '0;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    checked = 0;
    r = $urandom(12424);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ADDR_MODE, 32'h0, 32'hFF);
    rd(`ADDR_CTRL, 32'h0, 32'hF);
    rd(10'h010, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
    wr(10'h010, 32'h1, `RESP_SLVERR);
    $display("reset and map done");
    wr(`ADDR_CNT0, 32'hFFFE);
    wr(`ADDR_MODE, 32'h09);
    wr(`ADDR_CTRL, 32'h1);
    idle();
    rd(`ADDR_CNT0, 32'hFFFE, 32'hFFFF);
    external_gate_pin_zero <= 1'b1;
    idle();
    rd(`ADDR_CTRL, 32'h4, 32'h4);
    rd(`ADDR_CNT0, 32'h0, 32'hFF00);
    wr(`ADDR_CTRL, 32'hC);
    rd(`ADDR_CTRL, 32'h0, 32'hF);
    $display("mode 1 gated done");
    wr(`ADDR_CNT0, 32'hFF1E);
    wr(`ADDR_MODE, 32'h00);
    wr(`ADDR_CTRL, 32'h1);
    idle(30);
    rd(`ADDR_CTRL, 32'h4, 32'h4);
    rd(`ADDR_CNT0, 32'h0, 32'hFF00);
    wr(`ADDR_CTRL, 32'hC);
    $display("mode 0 done");
    wr(`ADDR_CNT1, 32'hABFD);
    wr(`ADDR_MODE, 32'hE0);
    wr(`ADDR_CTRL, 32'h2);
    pulse(1'b1, 8'h3);
    rd(`ADDR_CNT1, 32'hABFD, 32'hFFFF);
    external_gate_pin_one <= 1'b1;
    pulse(1'b1, 8'h3);
    rd(`ADDR_CNT1, 32'hABAB, 32'hFFFF);
    rd(`ADDR_CTRL, 32'hA, 32'hF);
    @(negedge aclk);
    cmp_resp("flags", 2'h2, {overflow_flag_one, overflow_flag_zero});
    wr(`ADDR_CTRL, 32'hC);
    $display("mode 2 counter done");
    wr(`ADDR_CNT1, r & 32'hFFFF);
    wr(`ADDR_CNT0, 32'hFFFE);
    wr(`ADDR_MODE, 32'h37);
    wr(`ADDR_CTRL, 32'h2);
    idle(30);
    rd(`ADDR_CNT1, r, 32'hFFFF);
    rd(`ADDR_CTRL, 32'hA, 32'hF);
    rd(`ADDR_CNT0, 32'hFE, 32'hFF);
    wr(`ADDR_CTRL, 32'hD);
    pulse(1'b0, 8'h2);
    rd(`ADDR_CTRL, 32'h5, 32'hF);
    rd(`ADDR_CNT0, 32'h0, 32'hFF);
    rd(`ADDR_MODE, 32'h37, 32'hFF);
    wr(`ADDR_CNT1, 32'h1E);
    wr(`ADDR_MODE, 32'h07);
    idle(30);
    rd(`ADDR_CNT1, 32'h100, 32'hFF00);
    @(negedge aclk);
    cmp_resp("flags", 2'h1, {overflow_flag_one, overflow_flag_zero});
    $display("mode 3 done");
    end_sim();
  end
endmodule
`default_nettype wire

/* tmr_defs.vh */
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH
// Register index of the mode register; its byte address is four times it
`define MODE_REG_INDEX 10'h089
// Byte addresses of the registers
`define ADDR_MODE      10'h224
`define ADDR_CTRL      10'h004
`define ADDR_CNT0      10'h008
`define ADDR_CNT1      10'h00C
// Mode register field positions
`define GATE1_BIT      7
`define SRC1_BIT       6
`define GATE0_BIT      3
`define SRC0_BIT       2
// Control register field positions
`define RUN0_BIT       0
`define RUN1_BIT       1
`define OVF0_BIT       2
`define OVF1_BIT       3
// Mode codes
`define MODE_13BIT     2'h0
`define MODE_16BIT     2'h1
`define MODE_RELOAD    2'h2
`define MODE_SPLIT     2'h3
// Reset values and timing
`define MODE_RESET     8'h00
`define PRESCALE_MAX   5'h1F
`define MCYCLE_DIV     4'hB
// Bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

/* tmr_mcycle.v */
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defs.vh"
// Machine-cycle tick, one pulse every twelve clocks
module tmr_mcycle (
  input  wire aclk,
  input  wire aresetn,
  output reg  tick
);
  reg [3:0] cnt_q;
  // Divider
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 4'h0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_q == `MCYCLE_DIV);
      cnt_q <= (cnt_q == `MCYCLE_DIV) ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* tmr_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defs.vh"
// Bus answer timing and overflow flag checks
module tmr_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        overflow_flag_zero,
  input wire logic        overflow_flag_one
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_flags_a: assert property ($rose(aresetn) |-> !overflow_flag_zero && !overflow_flag_one)
    else $error("flag set after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
  flag0_sticky_a: assert property ($fell(overflow_flag_zero) |-> $past(s_axi_wready) || $past(s_axi_wready, 2))
    else $error("flag 0 fell alone");
  flag1_sticky_a: assert property ($fell(overflow_flag_one) |-> $past(s_axi_wready) || $past(s_axi_wready, 2))
    else $error("flag 1 fell alone");
endmodule
bind tmr_top tmr_monitor tmr_monitor_i (.*);
`default_nettype wire

/* tmr_pins.sv */
`timescale 1ns/10ps
`default_nettype none
// Count pin source: n falls on the selected pin, 8 clocks per level
module tmr_pins (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic       sel,
  input  wire logic [7:0] n,
  output wire logic [1:0] cnt_pin,
  output wire logic       busy
);
  logic [8:0] left_q = 9'h000;
  logic [2:0] t_q = 3'h0;
  // Level counter, pins idle high between bursts
  always @(posedge aclk) begin
    t_q <= t_q + 3'h1;
    if (go) begin
      left_q <= {n, 1'b0};
    end else if (busy && t_q == 3'h7) begin
      left_q <= left_q - 9'h001;
    end
  end
  assign busy = left_q != 9'h000;
  assign cnt_pin = {sel ? ~left_q[0] : 1'b1, sel ? 1'b1 : ~left_q[0]};
endmodule
`default_nettype wire

/* tmr_sync.v */
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser with falling edge detect
module tmr_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin,
  output wire level,
  output wire fall
);
  reg meta_q;
  reg sync_q;
  reg last_q;
  // Sync chain
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign level = sync_q;
  assign fall  = last_q & ~sync_q;
endmodule
`default_nettype wire

/* tmr_top.v */
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "tmr_defs.vh"
module tmr_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        external_gate_pin_zero,
  input  wire        external_gate_pin_one,
  input  wire        count_input_pin_zero,
  input  wire        count_input_pin_one,
  output reg         overflow_flag_zero,
  output reg         overflow_flag_one
);
  wire       tick;
  wire       gate0_lvl;
  wire       gate1_lvl;
  wire       cnt0_fall;
  wire       cnt1_fall;
  reg  [7:0] timer_mode_control_q;
  reg        run_bit_zero_q;
  reg        run_bit_one_q;
  reg  [7:0] count_low_byte_zero_q;
  reg  [7:0] count_high_byte_zero_q;
  reg  [7:0] count_low_byte_one_q;
  reg  [7:0] count_high_byte_one_q;
  reg  [4:0] pre0_q;
  reg  [4:0] pre1_q;
  reg  [9:0] aw_q;
  reg        aw_have_q;
  reg [31:0] w_q;
  reg  [3:0] ws_q;
  reg        w_have_q;

  tmr_mcycle u_mcycle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );
  // Pin synchronisers: gate levels and count pin falls
  tmr_sync u_g0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (external_gate_pin_zero),
    .level   (gate0_lvl),
    .fall    ()
  );
  tmr_sync u_g1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (external_gate_pin_one),
    .level   (gate1_lvl),
    .fall    ()
  );
  tmr_sync u_c0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (count_input_pin_zero),
    .level   (),
    .fall    (cnt0_fall)
  );
  tmr_sync u_c1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (count_input_pin_one),
    .level   (),
    .fall    (cnt1_fall)
  );

  // Mode fields
  wire [1:0] mode0 = timer_mode_control_q[1:0];
  wire [1:0] mode1 = timer_mode_control_q[5:4];
  wire       split = (mode0 == `MODE_SPLIT);

  // Count events per timer
  wire src0 = timer_mode_control_q[`SRC0_BIT] ? cnt0_fall : tick;
  wire src1 = timer_mode_control_q[`SRC1_BIT] ? cnt1_fall : tick;
  wire en0  = run_bit_zero_q & (~timer_mode_control_q[`GATE0_BIT] | gate0_lvl);
  // Timer 1 run: while timer 0 is split its run bit serves the high byte
  wire run1 = split | run_bit_one_q;
  wire en1  = run1 & (~timer_mode_control_q[`GATE1_BIT] | gate1_lvl) &
              (mode1 != `MODE_SPLIT);
  wire inc0 = en0 & src0;
  wire inc1 = en1 & src1;
  wire inc0h = split & run_bit_one_q & tick;

  // Write channel decode
  wire       wr_go  = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire       wr_ok  = (aw_q == `ADDR_MODE) | (aw_q == `ADDR_CTRL) |
                      (aw_q == `ADDR_CNT0) | (aw_q == `ADDR_CNT1);

  // Write targets, decoded once
  wire       wr_mode = wr_go & (aw_q == `ADDR_MODE);
  wire       wr_ctrl = wr_go & (aw_q == `ADDR_CTRL) & ws_q[0];
  wire       wr_cnt0 = wr_go & (aw_q == `ADDR_CNT0);
  wire       wr_cnt1 = wr_go & (aw_q == `ADDR_CNT1);

  // Apply byte strobes
  function [7:0] merge;
    input [7:0] old;
    input [7:0] nw;
    input       en;
    begin
      merge = en ? nw : old;
    end
  endfunction

  // One timer step: returns {overflow, high, low}
  function [16:0] step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    input [4:0] pre;
    reg   [8:0] s;
    begin
      s = 9'h000;
      case (mode)
        `MODE_13BIT: begin
          if (pre == `PRESCALE_MAX) begin
            s = {1'b0, hi} + 9'h001;
            step = {s[8], s[7:0], lo[7:5], 5'h00};
          end else begin
            step = {1'b0, hi, lo[7:5], pre + 5'h01};
          end
        end
        `MODE_16BIT: begin
          if (lo == 8'hFF) begin
            s = {1'b0, hi} + 9'h001;
            step = {s[8], s[7:0], 8'h00};
          end else begin
            step = {1'b0, hi, lo + 8'h01};
          end
        end
        `MODE_RELOAD: begin
          if (lo == 8'hFF) step = {1'b1, hi, hi};
          else step = {1'b0, hi, lo + 8'h01};
        end
        default: begin
          if (lo == 8'hFF) step = {1'b1, hi, 8'h00};
          else step = {1'b0, hi, lo + 8'h01};
        end
      endcase
    end
  endfunction

  wire [16:0] nxt0 = step(mode0, count_high_byte_zero_q, count_low_byte_zero_q, pre0_q);
  wire [16:0] nxt1 = step(mode1, count_high_byte_one_q, count_low_byte_one_q, pre1_q);
  wire        ovf0h = inc0h & (count_high_byte_zero_q == 8'hFF);
  wire        ovf0 = inc0 & nxt0[16];
  wire        ovf1 = (inc1 & nxt1[16] & ~split) | ovf0h;

  // Bus slave: capture address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_q          <= 10'h000;
      w_q           <= 32'h0000_0000;
      ws_q          <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q      <= s_axi_awaddr[9:0];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q      <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr[9:0])
          `ADDR_MODE: s_axi_rdata <= {24'h000000, timer_mode_control_q};
          `ADDR_CTRL: s_axi_rdata <= {28'h0000000, overflow_flag_one, overflow_flag_zero,
                                      run_bit_one_q, run_bit_zero_q};
          `ADDR_CNT0: s_axi_rdata <= {16'h0000, count_high_byte_zero_q, count_low_byte_zero_q};
          `ADDR_CNT1: s_axi_rdata <= {16'h0000, count_high_byte_one_q, count_low_byte_one_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Timer state, bus writes and counting
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_mode_control_q   <= `MODE_RESET;
      run_bit_zero_q         <= 1'b0;
      run_bit_one_q          <= 1'b0;
      overflow_flag_zero     <= 1'b0;
      overflow_flag_one      <= 1'b0;
      count_low_byte_zero_q  <= 8'h00;
      count_high_byte_zero_q <= 8'h00;
      count_low_byte_one_q   <= 8'h00;
      count_high_byte_one_q  <= 8'h00;
      pre0_q                 <= 5'h00;
      pre1_q                 <= 5'h00;
    end else begin
      // Counting first; bus writes to counts take over below
      if (inc0) begin
        count_low_byte_zero_q <= nxt0[7:0];
        pre0_q                <= nxt0[4:0];
        if (!split) count_high_byte_zero_q <= nxt0[15:8];
      end
      if (inc0h) count_high_byte_zero_q <= count_high_byte_zero_q + 8'h01;
      if (inc1) begin
        count_low_byte_one_q  <= nxt1[7:0];
        count_high_byte_one_q <= nxt1[15:8];
        pre1_q                <= nxt1[4:0];
      end
      if (wr_mode)
        timer_mode_control_q <= merge(timer_mode_control_q, w_q[7:0], ws_q[0]);
      // Run bits only; counts stay as they are
      if (wr_ctrl) begin
        run_bit_zero_q <= w_q[`RUN0_BIT];
        run_bit_one_q  <= w_q[`RUN1_BIT];
      end
      if (wr_cnt0) begin
        count_low_byte_zero_q  <= merge(count_low_byte_zero_q, w_q[7:0], ws_q[0]);
        count_high_byte_zero_q <= merge(count_high_byte_zero_q, w_q[15:8], ws_q[1]);
        if (ws_q[0]) pre0_q <= w_q[4:0];
      end
      if (wr_cnt1) begin
        count_low_byte_one_q  <= merge(count_low_byte_one_q, w_q[7:0], ws_q[0]);
        count_high_byte_one_q <= merge(count_high_byte_one_q, w_q[15:8], ws_q[1]);
        if (ws_q[0]) pre1_q <= w_q[4:0];
      end
      // Flags: write one to clear, a new overflow wins
      if (ovf0) overflow_flag_zero <= 1'b1;
      else if (wr_ctrl & w_q[`OVF0_BIT]) overflow_flag_zero <= 1'b0;
      if (ovf1) overflow_flag_one <= 1'b1;
      else if (wr_ctrl & w_q[`OVF1_BIT]) overflow_flag_one <= 1'b0;
    end
  end
endmodule
`default_nettype wire
